// file: verilog/rwtc_pkg.sv
// constants and types shared by the reset, watchdog and timer control block
package rwtc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 100;
    // one free-running count per microsecond
    localparam int unsigned TIMER_RES_NS = 1000;
    localparam int unsigned CYC_PER_US = TIMER_RES_NS / CLK_PERIOD_NS;
    localparam int unsigned SE0_MIN_NS = 8000;
    localparam int unsigned SE0_MAX_NS = 16000;
    localparam int unsigned SE0_MIN_CYC = (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDR_HOLD_NS = 8192000;
    localparam int unsigned WDR_HOLD_CYC = (WDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned IO_W = 8;
    localparam int unsigned TIMER_W = 8;
    localparam int unsigned CHAIN_W = 10;
    localparam int unsigned PRESC_W = 4;
    localparam int unsigned WD_W = 4;
    localparam int unsigned SE0_W = 7;
    localparam int unsigned HOLD_W = 17;
    localparam int unsigned PC_W = 14;
    localparam int unsigned SP_W = 8;
    localparam int unsigned DEV_ADDR_W = 7;

    localparam logic [IO_W-1:0] ADDR_WD_RESTART = 8'h21;
    localparam logic [IO_W-1:0] ADDR_FREE_COUNT = 8'h23;
    localparam logic [IO_W-1:0] ADDR_SYS_STATUS = 8'hff;

    localparam int unsigned ST_RUN_BIT = 0;
    localparam int unsigned ST_SUSPEND_BIT = 3;
    localparam int unsigned ST_POR_BIT = 4;
    localparam int unsigned ST_USB_BIT = 5;
    localparam int unsigned ST_WDR_BIT = 6;
    localparam logic [IO_W-1:0] STATUS_POR_VALUE = 8'h19;
    localparam logic [IO_W-1:0] STATUS_LIVE_MASK = 8'h79;
    localparam logic [IO_W-1:0] STATUS_RUN_ONLY = 8'h01;
    localparam logic [IO_W-1:0] STATUS_WDR_ONLY = 8'h40;
    localparam logic [IO_W-1:0] STATUS_USB_ONLY = 8'h20;

    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(CYC_PER_US - 1);
    localparam logic [6:0] TICK128_LAST = 7'h7f;
    localparam logic [CHAIN_W-1:0] TICK1MS_LAST = 10'h3ff;
    localparam logic [WD_W-1:0] WD_BEFORE_TOP = 4'h7;
    localparam logic [SE0_W-1:0] SE0_DET_AT = SE0_W'(SE0_MIN_CYC - 1);
    localparam logic [SE0_W-1:0] SE0_SAT = SE0_W'(SE0_MIN_CYC);

    localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;
    localparam logic [SP_W-1:0] PSP_RESET = 8'h00;
    localparam logic [SP_W-1:0] DSP_RESET = 8'h00;
    localparam logic [DEV_ADDR_W-1:0] DEV_ADDR_RESET = 7'h00;
    localparam logic [IO_W-1:0] INT_ENABLE_RESET = 8'h00;

    // low-speed idle (J): data plus low, data minus high
    localparam logic IDLE_DP = 1'b0;
    localparam logic IDLE_DM = 1'b1;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [IO_W-1:0] addr;
        logic [IO_W-1:0] wdata;
    } rwtc_io_req_t;

    typedef struct packed {
        logic dp;
        logic dm;
    } rwtc_usb_lines_t;

    typedef struct packed {
        logic load;
        logic [SP_W-1:0] program_stack_pointer;
        logic [SP_W-1:0] dsp;
        logic [DEV_ADDR_W-1:0] dev_addr;
        logic [IO_W-1:0] int_enable;
    } rwtc_reset_load_t;

    typedef enum logic [1:0] {
        RWTC_SUSPEND,
        RWTC_RUN,
        RWTC_WDR_HOLD,
        RWTC_USB_HOLD
    } rwtc_state_t;

endpackage

// file: verilog/rwtc_timebase.sv
// free-running microsecond timer with the 128 us and 1.024 ms event ticks
`timescale 1ns/1ps
`default_nettype none
module rwtc_timebase (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic clear_i,
    output logic [rwtc_pkg::TIMER_W-1:0] count_o,
    output logic tick_128us_o,
    output logic tick_1ms_o
);
    import rwtc_pkg::*;

    logic [PRESC_W-1:0] presc_reg, presc_next;
    logic [CHAIN_W-1:0] chain_reg, chain_next;
    logic t128_reg, t128_next;
    logic t1ms_reg, t1ms_next;

    always_comb begin
        presc_next = presc_reg;
        chain_next = chain_reg;
        t128_next = 1'b0;
        t1ms_next = 1'b0;
        if (clear_i) begin
            presc_next = '0;
            chain_next = '0;
        end else if (run_i) begin
            if (presc_reg == PRESC_LAST) begin
                presc_next = '0;
                chain_next = chain_reg + 1'b1;
                t128_next = (chain_reg[6:0] == TICK128_LAST);
                t1ms_next = (chain_reg == TICK1MS_LAST);
            end else begin
                presc_next = presc_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            presc_reg <= '0;
            chain_reg <= '0;
            t128_reg <= 1'b0;
            t1ms_reg <= 1'b0;
        end else begin
            presc_reg <= presc_next;
            chain_reg <= chain_next;
            t128_reg <= t128_next;
            t1ms_reg <= t1ms_next;
        end
    end

    assign count_o = chain_reg[TIMER_W-1:0];
    assign tick_128us_o = t128_reg;
    assign tick_1ms_o = t1ms_reg;

    tick_nest_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        tick_1ms_o |-> tick_128us_o)
        else $error("1.024 ms tick without 128 us tick");

    tick_gap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (tick_128us_o && run_i && !clear_i) [*1] |=> !tick_128us_o [*8])
        else $error("128 us ticks too close");

endmodule
`default_nettype wire

// file: verilog/rwtc_ctrl.sv
// reset source handling, reset cause, run/suspend control and watchdog
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - any reset restores register defaults and disables every interrupt source
// - any reset clears the USB device address to zero
// - any reset loads program and data stack pointers with zero
// - status register at 0xff records power-on, bus and watchdog reset causes
// - clearing the run bit halts the processor; only a reset sets it again
// - processor starts at address zero after reset unless suspend is set
// - suspend stops oscillator and timers and powers down the processor
// - any detected bus activity ends suspend
// - power-on reset loads status 00011001 and leaves the device suspended
// - after power-on, only a non-idle bus state ends suspend
// - 4-bit watchdog advances per 1.024 ms tick, fires when its top bit rises
// - any write to 0x21 clears the watchdog counter
// - watchdog reset sets bit 6, holds processor in reset 8.192 ms
// - after watchdog reset transmitter stays off until firmware clears bit 6
// - bus reset recognised between 8 and 16 us of single-ended zero
// - both data lines low is single-ended zero; bus reset sets bit 5
// - bus reset in suspend wakes device, holds processor until SE0 ends
// - 8-bit free-running counter reads at 0x23 and ignores writes
// - free-running counter cleared by power-on and on suspend entry
// - timer raises events every 128 us and every 1.024 ms
// - on wake timers restart at once, processor running within 256 us
module rwtc_ctrl #(
    parameter int unsigned WDR_HOLD_CYCLES = rwtc_pkg::WDR_HOLD_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire rwtc_pkg::rwtc_io_req_t io_req_i,
    input wire rwtc_pkg::rwtc_usb_lines_t usb_lines_i,
    output logic [rwtc_pkg::IO_W-1:0] io_rdata_o,
    output logic cpu_reset_o,
    output logic cpu_run_o,
    output logic [rwtc_pkg::PC_W-1:0] cpu_start_pc_o,
    output logic osc_enable_o,
    output logic usb_tx_enable_o,
    output rwtc_pkg::rwtc_reset_load_t reset_load_o,
    output logic tick_128us_o,
    output logic tick_1ms_o
);
    import rwtc_pkg::*;

    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(WDR_HOLD_CYCLES - 1);

    function automatic logic io_write_to(input rwtc_io_req_t req, input logic [IO_W-1:0] a);
        io_write_to = req.wr && (req.addr == a);
    endfunction

    rwtc_state_t state_reg, state_next;
    logic [IO_W-1:0] status_reg, status_next;
    logic [WD_W-1:0] wd_reg, wd_next;
    logic [SE0_W-1:0] se0_cnt_reg, se0_cnt_next;
    logic [HOLD_W-1:0] hold_reg, hold_next;
    logic [IO_W-1:0] rdata_reg, rdata_next;
    rwtc_reset_load_t load_reg, load_next;
    logic [PC_W-1:0] pc_reg;

    logic se0;
    logic bus_idle;
    logic usb_det;
    logic wd_restart;
    logic wd_fire;
    logic status_wr;
    logic timer_clear;
    logic timer_run;
    logic [TIMER_W-1:0] timer_count;

    // both data lines low is single-ended zero
    assign se0 = !usb_lines_i.dp && !usb_lines_i.dm;
    assign bus_idle = (usb_lines_i.dp == IDLE_DP) && (usb_lines_i.dm == IDLE_DM);
    // recognised at the lower bound so the upper bound always holds
    assign usb_det = se0 && (se0_cnt_reg == SE0_DET_AT);
    assign wd_restart = io_write_to(io_req_i, ADDR_WD_RESTART);
    assign status_wr = io_write_to(io_req_i, ADDR_SYS_STATUS);
    // the next tick would lift the top bit from low to high
    assign wd_fire = (state_reg == RWTC_RUN) && tick_1ms_o && !wd_restart
        && (wd_reg == WD_BEFORE_TOP);
    assign timer_run = (state_reg != RWTC_SUSPEND);

    rwtc_timebase u_timebase (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .run_i(timer_run),
        .clear_i(timer_clear),
        .count_o(timer_count),
        .tick_128us_o(tick_128us_o),
        .tick_1ms_o(tick_1ms_o)
    );

    // single-ended zero duration counter; the receiver stays alive in suspend
    always_comb begin
        se0_cnt_next = se0_cnt_reg;
        if (!se0) begin
            se0_cnt_next = '0;
        end else if (se0_cnt_reg != SE0_SAT) begin
            se0_cnt_next = se0_cnt_reg + 1'b1;
        end
    end

    // reset sequencing, status register and watchdog
    always_comb begin
        state_next = state_reg;
        status_next = status_reg;
        wd_next = wd_reg;
        hold_next = hold_reg;
        timer_clear = 1'b0;
        load_next = load_reg;
        load_next.load = 1'b0;
        if (wd_restart) begin
            wd_next = '0;
        end else if (tick_1ms_o && (state_reg == RWTC_RUN)) begin
            wd_next = wd_reg + 1'b1;
        end
        if (usb_det) begin
            // bus reset wins over every other event; the watchdog flag is
            // kept so firmware can still see that the transmitter is off
            state_next = RWTC_USB_HOLD;
            status_next = STATUS_RUN_ONLY | STATUS_USB_ONLY
                | (status_reg & STATUS_WDR_ONLY);
            wd_next = '0;
            load_next.load = 1'b1;
        end else begin
            case (state_reg)
                RWTC_SUSPEND: begin
                    if (!bus_idle) begin
                        state_next = RWTC_RUN;
                        status_next[ST_SUSPEND_BIT] = 1'b0;
                    end
                end
                RWTC_RUN: begin
                    if (wd_fire) begin
                        state_next = RWTC_WDR_HOLD;
                        hold_next = '0;
                        status_next = STATUS_RUN_ONLY | STATUS_WDR_ONLY;
                        wd_next = '0;
                        load_next.load = 1'b1;
                    end else if (status_wr) begin
                        // run can only be cleared; flags only cleared by writing zero
                        status_next[ST_RUN_BIT] = status_reg[ST_RUN_BIT]
                            & io_req_i.wdata[ST_RUN_BIT];
                        status_next[ST_POR_BIT] = status_reg[ST_POR_BIT]
                            & io_req_i.wdata[ST_POR_BIT];
                        status_next[ST_USB_BIT] = status_reg[ST_USB_BIT]
                            & io_req_i.wdata[ST_USB_BIT];
                        status_next[ST_WDR_BIT] = status_reg[ST_WDR_BIT]
                            & io_req_i.wdata[ST_WDR_BIT];
                        status_next[ST_SUSPEND_BIT] = io_req_i.wdata[ST_SUSPEND_BIT];
                        if (io_req_i.wdata[ST_SUSPEND_BIT]) begin
                            state_next = RWTC_SUSPEND;
                            timer_clear = 1'b1;
                        end
                    end
                end
                RWTC_WDR_HOLD: begin
                    if (hold_reg == HOLD_LAST) begin
                        state_next = RWTC_RUN;
                    end else begin
                        hold_next = hold_reg + 1'b1;
                    end
                end
                RWTC_USB_HOLD: begin
                    if (!se0) begin
                        state_next = RWTC_RUN;
                    end
                end
                default: begin
                    state_next = RWTC_SUSPEND;
                end
            endcase
        end
        status_next = status_next & STATUS_LIVE_MASK;
    end

    // register read port; the timer ignores writes and 0x21 reads back as zero
    always_comb begin
        rdata_next = '0;
        if (io_req_i.rd) begin
            case (io_req_i.addr)
                ADDR_FREE_COUNT: rdata_next = timer_count;
                ADDR_SYS_STATUS: rdata_next = status_reg & STATUS_LIVE_MASK;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= RWTC_SUSPEND;
            status_reg <= STATUS_POR_VALUE;
            wd_reg <= '0;
            se0_cnt_reg <= '0;
            hold_reg <= '0;
            rdata_reg <= '0;
            load_reg <= '{load: 1'b1, program_stack_pointer: PSP_RESET, dsp: DSP_RESET,
                dev_addr: DEV_ADDR_RESET, int_enable: INT_ENABLE_RESET};
            pc_reg <= RESET_VECTOR;
        end else begin
            state_reg <= state_next;
            status_reg <= status_next;
            wd_reg <= wd_next;
            se0_cnt_reg <= se0_cnt_next;
            hold_reg <= hold_next;
            rdata_reg <= rdata_next;
            load_reg <= load_next;
            pc_reg <= RESET_VECTOR;
        end
    end

    assign io_rdata_o = rdata_reg;
    assign reset_load_o = load_reg;
    assign cpu_start_pc_o = pc_reg;
    assign cpu_reset_o = (state_reg == RWTC_WDR_HOLD) || (state_reg == RWTC_USB_HOLD);
    // processor only fetches while running, un-halted and not suspended
    assign cpu_run_o = (state_reg == RWTC_RUN) && status_reg[ST_RUN_BIT]
        && !status_reg[ST_SUSPEND_BIT];
    assign osc_enable_o = (state_reg != RWTC_SUSPEND);
    // the device address was cleared, so answering would hit address 0 traffic
    assign usb_tx_enable_o = !status_reg[ST_WDR_BIT];

    por_status_a: assert property (@(posedge clk_sys_i)
        $fell(rst_i) |-> (status_reg == STATUS_POR_VALUE) && !osc_enable_o && !cpu_run_o)
        else $error("power-on state wrong");

    run_sticky_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!status_reg[ST_RUN_BIT] && !usb_det && !wd_fire) |=> !status_reg[ST_RUN_BIT])
        else $error("run bit set without reset");

    wdr_entry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wd_fire && !usb_det) |=> status_reg[ST_WDR_BIT] && cpu_reset_o && reset_load_o.load
            && !usb_tx_enable_o)
        else $error("watchdog reset entry wrong");

    wdr_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_reg == RWTC_WDR_HOLD && hold_reg == HOLD_LAST && !usb_det)
            |=> !cpu_reset_o && state_reg == RWTC_RUN)
        else $error("watchdog hold release wrong");

    wd_restart_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wd_restart |=> (wd_reg == '0))
        else $error("watchdog not cleared by restart write");

    wd_fire_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_reg == RWTC_RUN && tick_1ms_o && wd_reg == WD_BEFORE_TOP
            && !wd_restart && !usb_det) |=> (state_reg == RWTC_WDR_HOLD))
        else $error("watchdog did not fire");

    tx_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!usb_tx_enable_o && !(status_wr && !io_req_i.wdata[ST_WDR_BIT])) |=> !usb_tx_enable_o)
        else $error("transmitter enabled with watchdog flag set");

    usb_detect_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (se0 && se0_cnt_reg == '0) ##1 se0 [*8] |-> !usb_det)
        else $error("bus reset recognised too early");

    usb_cause_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        usb_det |=> status_reg[ST_USB_BIT] && !status_reg[ST_SUSPEND_BIT] && osc_enable_o)
        else $error("bus reset not recorded");

    usb_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_reg == RWTC_USB_HOLD && se0) |=> cpu_reset_o)
        else $error("processor released during single-ended zero");

    wake_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (state_reg == RWTC_SUSPEND && !bus_idle && !usb_det) |=> osc_enable_o
            && !status_reg[ST_SUSPEND_BIT])
        else $error("bus activity did not end suspend");

    suspend_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        timer_clear |=> (timer_count == '0) && !osc_enable_o)
        else $error("timer not cleared on suspend entry");

    timer_ro_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (io_req_i.rd && io_req_i.addr == ADDR_FREE_COUNT) |=> (io_rdata_o == $past(timer_count)))
        else $error("timer read value wrong");

endmodule
`default_nettype wire

// file: tb/rwtc_usb_host.sv
// upstream bus model: drives the two USB data lines of the block
`timescale 1ns/1ps
`default_nettype none
module rwtc_usb_host (
    input wire logic clk_sys_i,
    output var rwtc_pkg::rwtc_usb_lines_t lines_o
);
    import rwtc_pkg::*;
    initial begin
        lines_o = rwtc_usb_lines_t'({IDLE_DP, IDLE_DM});
    end
    // the host never floats the lines: both data lines low is the only SE0 it makes
    // state goes out on a rising edge and is sampled on exactly n edges
    task automatic hold(input logic [1:0] st, input int n);
        @(posedge clk_sys_i);
        lines_o <= rwtc_usb_lines_t'(st);
        repeat (n - 1) @(posedge clk_sys_i);
    endtask
endmodule
`default_nettype wire

// file: tb/rwtc_ctrl_test.sv
// self-checking bench for the reset, watchdog and timer control block
`timescale 1ns/1ps
`default_nettype none
module rwtc_ctrl_test;
    import rwtc_pkg::*;
    localparam int unsigned HOLD = 20;
    localparam logic [1:0] LJ = 2'h1;
    localparam logic [1:0] LK = 2'h2;
    localparam logic [1:0] LSE0 = 2'h0;
    logic clk_sys_i;
    logic rst_i;
    rwtc_io_req_t io_req;
    rwtc_usb_lines_t usb_lines;
    logic [IO_W-1:0] io_rdata;
    logic cpu_reset;
    logic cpu_run;
    logic [PC_W-1:0] start_pc;
    logic osc_en;
    logic tx_en;
    rwtc_reset_load_t rl;
    logic t128;
    logic t1ms;
    int miscompares;
    int n_tests;
    logic [IO_W-1:0] rd_q[$];
    logic rd_pend;
    logic seen_1ms;
    int c128;
    logic [31:0] seed;
    int n;
    int k;
    logic [IO_W-1:0] a;

    rwtc_ctrl #(.WDR_HOLD_CYCLES(HOLD)) dut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .io_req_i(io_req),
        .usb_lines_i(usb_lines),
        .io_rdata_o(io_rdata),
        .cpu_reset_o(cpu_reset),
        .cpu_run_o(cpu_run),
        .cpu_start_pc_o(start_pc),
        .osc_enable_o(osc_en),
        .usb_tx_enable_o(tx_en),
        .reset_load_o(rl),
        .tick_128us_o(t128),
        .tick_1ms_o(t1ms)
    );
    rwtc_usb_host host (
        .clk_sys_i(clk_sys_i),
        .lines_o(usb_lines)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic timeout();
        miscompares++;
        stop_test();
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one access per call; for a read d is the data expected back
    task automatic io(input logic rd, input logic [IO_W-1:0] ad, input logic [IO_W-1:0] d);
        @(posedge clk_sys_i);
        io_req <= '{rd: rd, wr: !rd, addr: ad, wdata: d};
        if (rd)
            rd_q.push_back(d);
        @(posedge clk_sys_i);
        io_req <= '0;
    endtask
    // sel 0: 128 us tick, 1: 1 ms tick, 2: processor released
    task automatic wait_sig(input int sel, input int bound);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            if (n > bound)
                timeout();
        end while (!((sel == 0 && t128 === 1'b1) || (sel == 1 && t1ms === 1'b1)
                     || (sel == 2 && cpu_reset === 1'b0)));
    endtask

    // read data lands one cycle after the request; tick ratio checked in passing
    always @(negedge clk_sys_i) begin
        if (rd_pend) begin
            if (rd_q.size() == 0)
                check("read queue", 32'h1, 32'h0);
            else
                check("io_rdata_o", 32'(io_rdata), 32'(rd_q.pop_front()));
        end
        rd_pend = io_req.rd;
        if (t128 === 1'b1)
            c128++;
        if (t1ms === 1'b1) begin
            if (seen_1ms)
                check("128us ticks per 1ms", c128, 8);
            c128 = 0;
            seen_1ms = 1'b1;
        end
        // a suspend clears the timer, so the ratio restarts with it
        if (osc_en !== 1'b1)
            seen_1ms = 1'b0;
    end

    initial begin
        rst_i = 1'b1;
        io_req = '0;
        seed = 32'h5f7cc124;
        rd_pend = 1'b0;
        seen_1ms = 1'b0;
        c128 = 0;
        miscompares = 0;
        n_tests = 0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check("reset_load_o", 32'(rl), 32'h0);
        check("osc_enable_o", 32'(osc_en), 32'h0);
        check("cpu_run_o", 32'(cpu_run), 32'h0);
        check("usb_tx_enable_o", 32'(tx_en), 32'h1);
        check("cpu_start_pc_o", 32'(start_pc), 32'h0);
        // firmware moves the data stack clear of the endpoint buffers itself
        check("reset_load_o dsp", 32'(rl.dsp), 32'h0);
        io(1'b1, ADDR_SYS_STATUS, 8'h19);
        io(1'b1, ADDR_FREE_COUNT, 8'h00);
        io(1'b1, ADDR_WD_RESTART, 8'h00);
        a = 8'(xs());
        if (a == ADDR_WD_RESTART || a == ADDR_FREE_COUNT || a == ADDR_SYS_STATUS)
            a = 8'h40;
        io(1'b1, a, 8'h00);
        host.hold(LJ, 50);
        @(negedge clk_sys_i);
        check("osc_enable_o idle bus", 32'(osc_en), 32'h0);
        host.hold(LK, 1);
        host.hold(LJ, 3);
        @(negedge clk_sys_i);
        check("osc_enable_o wake", 32'(osc_en), 32'h1);
        check("cpu_run_o wake", 32'(cpu_run), 32'h1);
        wait_sig(0, 2000);
        wait_sig(0, 2000);
        check("128us period", n, 128 * CYC_PER_US);
        // one cycle short of recognition must pass unnoticed
        host.hold(LSE0, 79);
        host.hold(LJ, 5);
        @(negedge clk_sys_i);
        check("cpu_reset_o short SE0", 32'(cpu_reset), 32'h0);
        host.hold(LSE0, 100);
        @(negedge clk_sys_i);
        check("cpu_reset_o SE0", 32'(cpu_reset), 32'h1);
        host.hold(LJ, 2);
        @(negedge clk_sys_i);
        check("cpu_reset_o after SE0", 32'(cpu_reset), 32'h0);
        io(1'b1, ADDR_SYS_STATUS, 8'h21);
        io(1'b0, ADDR_SYS_STATUS, 8'h09);
        @(negedge clk_sys_i);
        check("osc_enable_o suspend", 32'(osc_en), 32'h0);
        check("cpu_run_o suspend", 32'(cpu_run), 32'h0);
        io(1'b0, ADDR_FREE_COUNT, 8'(xs()));
        io(1'b1, ADDR_FREE_COUNT, 8'h00);
        host.hold(LSE0, 100);
        @(negedge clk_sys_i);
        check("osc_enable_o SE0 wake", 32'(osc_en), 32'h1);
        check("cpu_reset_o SE0 wake", 32'(cpu_reset), 32'h1);
        host.hold(LJ, 2);
        @(negedge clk_sys_i);
        check("cpu_run_o after SE0", 32'(cpu_run), 32'h1);
        // restart right after a tick, so an ignored restart fires one tick early
        wait_sig(1, 12000);
        io(1'b0, ADDR_WD_RESTART, 8'(xs()));
        k = 0;
        for (n = 0; cpu_reset !== 1'b1; n++) begin
            @(negedge clk_sys_i);
            if (t1ms === 1'b1)
                k++;
            if (n > 90000)
                timeout();
        end
        check("1ms ticks to watchdog", k, 8);
        check("reset_load_o watchdog", 32'(rl), 32'h8000_0000);
        check("usb_tx_enable_o watchdog", 32'(tx_en), 32'h0);
        wait_sig(2, 100);
        check("watchdog hold", n, HOLD);
        check("cpu_run_o after hold", 32'(cpu_run), 32'h1);
        io(1'b1, ADDR_SYS_STATUS, 8'h41);
        check("usb_tx_enable_o flag set", 32'(tx_en), 32'h0);
        io(1'b0, ADDR_SYS_STATUS, 8'h01);
        @(negedge clk_sys_i);
        check("usb_tx_enable_o flag clear", 32'(tx_en), 32'h1);
        io(1'b1, ADDR_SYS_STATUS, 8'h01);
        io(1'b0, ADDR_SYS_STATUS, 8'h00);
        @(negedge clk_sys_i);
        check("cpu_run_o halt", 32'(cpu_run), 32'h0);
        io(1'b0, ADDR_SYS_STATUS, 8'h01);
        @(negedge clk_sys_i);
        check("cpu_run_o rewrite", 32'(cpu_run), 32'h0);
        io(1'b1, ADDR_SYS_STATUS, 8'h00);
        host.hold(LSE0, 100);
        host.hold(LJ, 2);
        @(negedge clk_sys_i);
        check("cpu_run_o after reset", 32'(cpu_run), 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
